/* wp_pkg.sv */
/*
 * constants, register map and types of the peripheral write-protect block.
 * assumes a 32-bit register port with byte enables, one clock, one reset.
 */
`default_nettype none
package wp_pkg;
	localparam int NUM_GROUPS = 3;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int BE_W = 4;
	localparam int GROUP_W = 2;
	localparam int BIT_W = 5;
	localparam int NUM_EVENTS = 3;

	// -------------------------------------------------------------------
	// register map, byte addresses
	// -------------------------------------------------------------------
	localparam logic [ADDR_W-1:0] CLR_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] SET_OFS = 8'h04;
	localparam logic [ADDR_W-1:0] GROUP_BASE [NUM_GROUPS] = '{8'h00, 8'h10, 8'h20};
	localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 8'h30;
	localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 8'h34;

	// -------------------------------------------------------------------
	// peripheral bit positions
	// -------------------------------------------------------------------
	localparam int G0_EXT_IRQ_BIT = 6;
	localparam int G0_RTC_BIT = 5;
	localparam int G0_WDT_BIT = 4;
	localparam int G0_CLOCK_GEN_BIT = 3;
	localparam int G0_SYS_CONTROL_BIT = 2;
	localparam int G0_POWER_MANAGER_BIT = 1;
	localparam int G1_TRACE_BUFFER_BIT = 6;
	localparam int G1_IO_PORT_BIT = 3;
	localparam int G1_FLASH_CONTROL_BIT = 2;
	localparam int G1_SERVICE_BIT = 1;
	localparam int G2_TOUCH_BIT = 19;
	localparam int G2_DAC_BIT = 18;
	localparam int G2_COMPARATOR_BIT = 17;
	localparam int G2_ADC_BIT = 16;
	localparam int G2_TIMER_LSB = 8;
	localparam int G2_SERIAL_LSB = 2;
	localparam int G2_EVENT_ROUTER_BIT = 1;

	// -------------------------------------------------------------------
	// writable masks and reset values
	// -------------------------------------------------------------------
	localparam logic [DATA_W-1:0] G0_WR_MASK = 32'h0000_007E;
	localparam logic [DATA_W-1:0] G1_WR_MASK = 32'h0000_004E;
	localparam logic [DATA_W-1:0] G2_WR_MASK = 32'h000F_FFFE;
	localparam logic [DATA_W-1:0] G0_RESET = 32'h0000_0000;
	localparam logic [DATA_W-1:0] G1_RESET = 32'h0000_0002;
	localparam logic [DATA_W-1:0] G2_RESET = 32'h0080_0000;
	localparam logic [DATA_W-1:0] GROUP_WR_MASK [NUM_GROUPS] = '{G0_WR_MASK, G1_WR_MASK, G2_WR_MASK};
	localparam logic [DATA_W-1:0] GROUP_RESET [NUM_GROUPS] = '{G0_RESET, G1_RESET, G2_RESET};

	// -------------------------------------------------------------------
	// interrupt events
	// -------------------------------------------------------------------
	localparam int EV_DBL_SET = 0;
	localparam int EV_DBL_CLR = 1;
	localparam int EV_BLOCKED = 2;
	localparam logic [NUM_EVENTS-1:0] IRQ_MASK_RESET = 3'h0;

	typedef logic [NUM_EVENTS-1:0] events_t;
	typedef logic [DATA_W-1:0] word_t;
endpackage
`default_nettype wire

/* wp_if.sv */
/*
 * interfaces between the top and its protection groups and interrupt unit.
 * assumes wp_pkg is compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
interface wp_if;
	logic clr_stb;
	logic set_stb;
	logic [wp_pkg::DATA_W-1:0] wmask;
	logic [wp_pkg::DATA_W-1:0] state;
	logic dbl_set;
	logic dbl_clr;
	modport ctrl (output clr_stb, output set_stb, output wmask,
		input state, input dbl_set, input dbl_clr);
	modport group (input clr_stb, input set_stb, input wmask,
		output state, output dbl_set, output dbl_clr);
endinterface

interface irq_if;
	logic [wp_pkg::NUM_EVENTS-1:0] ev;
	logic stat_rd;
	logic mask_wr;
	logic [wp_pkg::NUM_EVENTS-1:0] mask_wdata;
	logic [wp_pkg::NUM_EVENTS-1:0] status;
	logic [wp_pkg::NUM_EVENTS-1:0] mask;
	logic irq;
	modport ctrl (output ev, output stat_rd, output mask_wr, output mask_wdata,
		input status, input mask, input irq);
	modport unit (input ev, input stat_rd, input mask_wr, input mask_wdata,
		output status, output mask, output irq);
endinterface
`default_nettype wire

/* wp_group.sv */
/*
 * one protection group: the shared state behind its clear and set registers.
 * assumes strobes of one cycle, never both at once, with lane-masked data.
 */
`timescale 1ns/1ps
`default_nettype none
module wp_group #(
	parameter logic [wp_pkg::DATA_W-1:0] WR_MASK = 32'h0000_0000,
	parameter logic [wp_pkg::DATA_W-1:0] RESET_VAL = 32'h0000_0000
) (
	input wire logic clk,
	input wire logic rst_n,
	wp_if.group port
);
	import wp_pkg::*;

	typedef struct packed {
		word_t prot;
	} group_state_t;

	group_state_t q;
	group_state_t d;
	word_t eff;

	assign eff = port.wmask & WR_MASK;
	assign port.state = q.prot;
	assign port.dbl_set = port.set_stb & (|(eff & q.prot));
	assign port.dbl_clr = port.clr_stb & (|(eff & ~q.prot));

	always_comb begin
		d = q;
		if (port.set_stb) begin
			d.prot = q.prot | eff;
		end
		if (port.clr_stb) begin
			d.prot = q.prot & ~eff;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q.prot <= RESET_VAL;
		end else begin
			q <= d;
		end
	end

	a_reset_value: assert property (@(posedge clk) $rose(rst_n) |-> q.prot == RESET_VAL)
		else $error("protection state differs from reset value");
	a_fixed_bits: assert property (@(posedge clk) disable iff (!rst_n)
		(q.prot & ~WR_MASK) == (RESET_VAL & ~WR_MASK))
		else $error("unassigned protection bit changed");
endmodule // wp_group
`default_nettype wire

/* wp_irq.sv */
/*
 * sticky event status, mask and one level interrupt.
 * assumes event inputs are one-cycle pulses on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module wp_irq (
	input wire logic clk,
	input wire logic rst_n,
	irq_if.unit port
);
	import wp_pkg::*;

	typedef struct packed {
		events_t status;
		events_t mask;
	} irq_state_t;

	irq_state_t q;
	irq_state_t d;

	assign port.status = q.status;
	assign port.mask = q.mask;
	assign port.irq = |(q.status & q.mask);

	always_comb begin
		d = q;
		// a read clears, but an event in the same cycle stays set
		if (port.stat_rd) begin
			d.status = '0;
		end
		d.status = d.status | port.ev;
		if (port.mask_wr) begin
			d.mask = port.mask_wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q.status <= '0;
			q.mask <= IRQ_MASK_RESET;
		end else begin
			q <= d;
		end
	end

	a_event_sticky: assert property (@(posedge clk) disable iff (!rst_n)
		|port.ev |=> ((q.status & $past(port.ev)) == $past(port.ev)))
		else $error("event not captured in status");
	a_read_clears: assert property (@(posedge clk) disable iff (!rst_n)
		port.stat_rd && port.ev == '0 |=> q.status == '0)
		else $error("status not cleared by read");
endmodule // wp_irq
`default_nettype wire

/* peripheral_write_protect.sv */
/*
 * peripheral write-protect controller: three protection groups, register
 * port, write guard for the peripheral bus path and an interrupt output.
 * assumes a register master on clk with one-cycle strobes and the bus path
 * presenting each peripheral write as a one-cycle request on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module peripheral_write_protect (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [wp_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [wp_pkg::DATA_W-1:0] reg_wdata,
	input wire logic [wp_pkg::BE_W-1:0] reg_be,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [wp_pkg::DATA_W-1:0] reg_rdata,
	output logic reg_err,
	input wire logic guard_wr_req,
	input wire logic [wp_pkg::GROUP_W-1:0] guard_wr_group,
	input wire logic [wp_pkg::BIT_W-1:0] guard_wr_bit,
	output logic guard_wr_block,
	output logic guard_wr_err,
	output logic [wp_pkg::DATA_W-1:0] prot_group0,
	output logic [wp_pkg::DATA_W-1:0] prot_group1,
	output logic [wp_pkg::DATA_W-1:0] prot_group2,
	output logic irq
);
	import wp_pkg::*;

	// -------------------------------------------------------------------
	// decode helpers
	// -------------------------------------------------------------------
	function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] base, input logic [ADDR_W-1:0] ofs);
		logic [ADDR_W-1:0] target;
		target = base + ofs;
		// byte address low bits select lanes through the enables only
		return addr[ADDR_W-1:2] == target[ADDR_W-1:2];
	endfunction

	function automatic word_t lane_mask(input logic [BE_W-1:0] be);
		word_t m;
		m = '0;
		for (int i = 0; i < BE_W; i++) begin
			m[i*8 +: 8] = {8{be[i]}};
		end
		return m;
	endfunction

	// -------------------------------------------------------------------
	// state
	// -------------------------------------------------------------------
	typedef struct packed {
		word_t rdata;
		logic reg_err;
		logic guard_err;
	} top_state_t;

	top_state_t q;
	top_state_t d;

	word_t wmask;
	word_t grp_state [NUM_GROUPS];
	logic [NUM_GROUPS-1:0] dbl_set_v;
	logic [NUM_GROUPS-1:0] dbl_clr_v;
	logic [NUM_GROUPS-1:0] clr_hit;
	logic [NUM_GROUPS-1:0] set_hit;
	logic sel_prot;
	logic stat_hit;
	logic mask_hit;

	wp_if gi [NUM_GROUPS] ();
	irq_if ii ();

	assign wmask = reg_wdata & lane_mask(reg_be);
	assign stat_hit = addr_hit(reg_addr, IRQ_STATUS_ADDR, 8'h00);
	assign mask_hit = addr_hit(reg_addr, IRQ_MASK_ADDR, 8'h00);

	// -------------------------------------------------------------------
	// protection groups
	// -------------------------------------------------------------------
	for (genvar g = 0; g < NUM_GROUPS; g++) begin : gen_group
		assign clr_hit[g] = addr_hit(reg_addr, GROUP_BASE[g], CLR_OFS);
		assign set_hit[g] = addr_hit(reg_addr, GROUP_BASE[g], SET_OFS);
		assign gi[g].clr_stb = reg_wr & clr_hit[g];
		assign gi[g].set_stb = reg_wr & set_hit[g];
		assign gi[g].wmask = wmask;
		assign grp_state[g] = gi[g].state;
		assign dbl_set_v[g] = gi[g].dbl_set;
		assign dbl_clr_v[g] = gi[g].dbl_clr;

		wp_group #(
			.WR_MASK(GROUP_WR_MASK[g]),
			.RESET_VAL(GROUP_RESET[g])
		) u_group (
			.clk(clk),
			.rst_n(rst_n),
			.port(gi[g])
		);
	end

	// -------------------------------------------------------------------
	// protection outputs to the bus path
	// -------------------------------------------------------------------
	assign prot_group0 = grp_state[0] & G0_WR_MASK;
	assign prot_group1 = grp_state[1] & G1_WR_MASK;
	assign prot_group2 = grp_state[2] & G2_WR_MASK;

	// -------------------------------------------------------------------
	// write guard
	// -------------------------------------------------------------------
	always_comb begin
		sel_prot = 1'b0;
		for (int g = 0; g < NUM_GROUPS; g++) begin
			if (guard_wr_group == GROUP_W'(g)) begin
				sel_prot = grp_state[g][guard_wr_bit] & GROUP_WR_MASK[g][guard_wr_bit];
			end
		end
	end

	assign guard_wr_block = guard_wr_req & sel_prot;
	assign guard_wr_err = q.guard_err;

	// -------------------------------------------------------------------
	// interrupt unit
	// -------------------------------------------------------------------
	assign ii.ev[EV_DBL_SET] = |dbl_set_v;
	assign ii.ev[EV_DBL_CLR] = |dbl_clr_v;
	assign ii.ev[EV_BLOCKED] = guard_wr_block;
	assign ii.stat_rd = reg_rd & stat_hit;
	assign ii.mask_wr = reg_wr & mask_hit & reg_be[0];
	assign ii.mask_wdata = reg_wdata[NUM_EVENTS-1:0];
	assign irq = ii.irq;

	wp_irq u_irq (
		.clk(clk),
		.rst_n(rst_n),
		.port(ii)
	);

	// -------------------------------------------------------------------
	// register read path and error answers
	// -------------------------------------------------------------------
	always_comb begin
		word_t rd;
		rd = '0;
		d = q;
		for (int g = 0; g < NUM_GROUPS; g++) begin
			if (clr_hit[g] || set_hit[g]) begin
				rd = grp_state[g];
			end
		end
		if (stat_hit) begin
			rd = {{(DATA_W-NUM_EVENTS){1'b0}}, ii.status};
		end
		if (mask_hit) begin
			rd = {{(DATA_W-NUM_EVENTS){1'b0}}, ii.mask};
		end
		d.rdata = reg_rd ? (rd & lane_mask(reg_be)) : '0;
		d.reg_err = reg_wr & ((|dbl_set_v) | (|dbl_clr_v));
		d.guard_err = guard_wr_block;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign reg_rdata = q.rdata;
	assign reg_err = q.reg_err;

	// -------------------------------------------------------------------
	// checks
	// -------------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_read_state: assert property (reg_rd && clr_hit[0] && reg_be == 4'hF
		|=> reg_rdata == $past(grp_state[0]))
		else $error("clear register read does not show state");
	a_set_mirror: assert property (reg_rd && set_hit[2] && reg_be == 4'hF
		|=> reg_rdata == $past(grp_state[2]))
		else $error("set register read differs from state");
	a_set_protects: assert property (reg_wr && set_hit[2]
		|=> (grp_state[2] & $past(wmask) & G2_WR_MASK) == ($past(wmask) & G2_WR_MASK))
		else $error("set write did not protect");
	a_clr_unprotects: assert property (reg_wr && clr_hit[1]
		|=> (grp_state[1] & $past(wmask) & G1_WR_MASK) == '0)
		else $error("clear write did not unprotect");
	a_zero_noop: assert property (reg_wr && (set_hit[0] || clr_hit[0]) && wmask == '0
		|=> $stable(grp_state[0]))
		else $error("zero write changed protection");
	a_lane_isolate: assert property (reg_wr && clr_hit[2] && reg_be == 4'h1
		|=> grp_state[2][31:8] == $past(grp_state[2][31:8]))
		else $error("byte write touched other lanes");
	a_guard_block: assert property (guard_wr_req && sel_prot
		|-> guard_wr_block ##1 guard_wr_err)
		else $error("protected write not blocked");
	a_guard_pass: assert property (!guard_wr_req |-> !guard_wr_block ##1 !guard_wr_err)
		else $error("guard error without request");
	a_double_set: assert property (reg_wr && set_hit[2]
		&& (|(wmask & G2_WR_MASK & grp_state[2])) |=> reg_err)
		else $error("double protect not answered with error");
	a_clean_write: assert property (reg_wr && set_hit[1]
		&& !(|(wmask & G1_WR_MASK & grp_state[1])) |=> !reg_err)
		else $error("error on clean protect");

	// -------------------------------------------------------------------
	// checks: register port and error answers
	// -------------------------------------------------------------------
	a_rdata_idle: assert property (
		!reg_rd
		|=> reg_rdata == '0)
		else $error("read data not zero outside a read");
	a_read_lanes: assert property (
		reg_rd && clr_hit[1]
		|=> reg_rdata == $past(grp_state[1] & lane_mask(reg_be)))
		else $error("lane-masked read shows wrong data");
	a_mirror_group1: assert property (
		reg_rd && set_hit[1] && reg_be == 4'hF
		|=> reg_rdata == $past(grp_state[1]))
		else $error("set register read differs from state");
	a_status_read: assert property (
		reg_rd && stat_hit && reg_be == 4'hF
		|=> reg_rdata == {{(DATA_W-NUM_EVENTS){1'b0}}, $past(ii.status)})
		else $error("status read shows wrong value");
	a_double_clr: assert property (
		reg_wr && clr_hit[0] && (|(wmask & G0_WR_MASK & ~grp_state[0]))
		|=> reg_err)
		else $error("double unprotect not answered with error");
	a_err_needs_write: assert property (
		!reg_wr
		|=> !reg_err)
		else $error("error answer without a write");
	a_clean_clear: assert property (
		reg_wr && clr_hit[2] && !(|(wmask & G2_WR_MASK & ~grp_state[2]))
		|=> !reg_err)
		else $error("error on clean unprotect");
	a_zero_clear: assert property (
		reg_wr && clr_hit[2] && wmask == '0
		|=> $stable(grp_state[2]))
		else $error("zero clear write changed protection");
	a_set_group0: assert property (
		reg_wr && set_hit[0]
		|=> (grp_state[0] & $past(wmask & G0_WR_MASK)) == $past(wmask & G0_WR_MASK))
		else $error("set write did not protect");
	a_clr_group2: assert property (
		reg_wr && clr_hit[2]
		|=> (grp_state[2] & $past(wmask & G2_WR_MASK)) == '0)
		else $error("clear write did not unprotect");

	// -------------------------------------------------------------------
	// checks: protection outputs, write guard and interrupt events
	// -------------------------------------------------------------------
	a_out_set: assert property (
		reg_wr && set_hit[1]
		|=> (prot_group1 & $past(wmask & G1_WR_MASK)) == $past(wmask & G1_WR_MASK))
		else $error("protection output misses a set");
	a_out_clear: assert property (
		reg_wr && clr_hit[2]
		|=> (prot_group2 & $past(wmask)) == '0)
		else $error("protection output misses a clear");
	a_out_follows_write: assert property (
		$changed(prot_group2)
		|-> $past(reg_wr))
		else $error("protection output changed without a write");
	a_unmapped_group: assert property (
		guard_wr_req && guard_wr_group == 2'h3
		|-> !guard_wr_block)
		else $error("write to unmapped group blocked");
	a_guard_free: assert property (
		guard_wr_req && guard_wr_group == 2'h1 && !grp_state[1][guard_wr_bit]
		|-> !guard_wr_block)
		else $error("write to unprotected peripheral blocked");
	a_guard_hit: assert property (
		guard_wr_req && guard_wr_group == 2'h2 && prot_group2[guard_wr_bit]
		|-> guard_wr_block)
		else $error("write to protected peripheral passed");
	a_err_follows: assert property (
		!guard_wr_block
		|=> !guard_wr_err)
		else $error("access error without a blocked write");
	a_blocked_status: assert property (
		guard_wr_block
		|=> ii.status[EV_BLOCKED])
		else $error("blocked write not in status");
	a_dbl_status: assert property (
		reg_wr && (|dbl_set_v)
		|=> ii.status[EV_DBL_SET])
		else $error("double protect not in status");
endmodule // peripheral_write_protect
`default_nettype wire

/* wp_bus_path_model.sv */
/*
 * model of the peripheral bus path that presents peripheral writes to the guard.
 * assumes the guard answers block in the same cycle and the error one cycle later.
 */
`timescale 1ns/1ps
`default_nettype none
module wp_bus_path_model (
	input wire logic clk,
	output logic guard_wr_req,
	output logic [wp_pkg::GROUP_W-1:0] guard_wr_group,
	output logic [wp_pkg::BIT_W-1:0] guard_wr_bit,
	input wire logic guard_wr_block,
	input wire logic guard_wr_err
);
	import wp_pkg::*;

	initial begin
		guard_wr_req = 1'b0;
		guard_wr_group = 2'h0;
		guard_wr_bit = 5'h00;
	end

	// -------------------------------------------------------------------
	// one peripheral write, held until the sampling edge
	// -------------------------------------------------------------------
	task automatic peri_write(input logic [GROUP_W-1:0] g, input logic [BIT_W-1:0] b,
			output logic blk, output logic err);
		@(posedge clk);
		guard_wr_req <= 1'b1;
		guard_wr_group <= g;
		guard_wr_bit <= b;
		#1 blk = guard_wr_block;
		@(posedge clk);
		// released target lines must not keep looking valid
		guard_wr_req <= 1'b0;
		guard_wr_group <= ~g;
		guard_wr_bit <= ~b;
		#1 err = guard_wr_err;
	endtask
endmodule // wp_bus_path_model
`default_nettype wire

/* test_peripheral_write_protect.sv */
/*
 * self-checking test of the peripheral write-protect block.
 * assumes wp_pkg, wp_if and the design modules are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
module test_peripheral_write_protect;
	import wp_pkg::*;

	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [ADDR_W-1:0] reg_addr = 8'h00;
	logic [DATA_W-1:0] reg_wdata = 32'h0000_0000;
	logic [BE_W-1:0] reg_be = 4'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	logic reg_err;
	logic guard_wr_req;
	logic [GROUP_W-1:0] guard_wr_group;
	logic [BIT_W-1:0] guard_wr_bit;
	logic guard_wr_block;
	logic guard_wr_err;
	wire [2:0][DATA_W-1:0] prot;
	logic irq;
	logic blk;
	logic err;
	int fail_count = 0;
	int checks = 0;
	logic [31:0] rst_v [3] = '{32'h0000_0000, 32'h0000_0002, 32'h0080_0000};
	logic [31:0] msk_v [3] = '{32'h0000_007E, 32'h0000_004E, 32'h000F_FFFE};

	always #5 clk = ~clk;

	peripheral_write_protect dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_be(reg_be), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .reg_err(reg_err), .guard_wr_req(guard_wr_req),
		.guard_wr_group(guard_wr_group), .guard_wr_bit(guard_wr_bit),
		.guard_wr_block(guard_wr_block), .guard_wr_err(guard_wr_err),
		.prot_group0(prot[0]), .prot_group1(prot[1]), .prot_group2(prot[2]), .irq(irq));

	wp_bus_path_model pm_u (.clk(clk), .guard_wr_req(guard_wr_req),
		.guard_wr_group(guard_wr_group), .guard_wr_bit(guard_wr_bit),
		.guard_wr_block(guard_wr_block), .guard_wr_err(guard_wr_err));

	// -------------------------------------------------------------------
	// compare, register access and verdict
	// -------------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
			input logic err_exp);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		reg_be <= be;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
		#1 chk(reg_err, err_exp);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [3:0] be, input logic [31:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		reg_be <= be;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask

	task automatic summarize();
		if (fail_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		#200_000;
		fail_count++;
		summarize();
	end

	// -------------------------------------------------------------------
	// tests
	// -------------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		for (int g = 0; g < 3; g++) begin
			rchk(GROUP_BASE[g] + CLR_OFS, 4'hF, rst_v[g]);
			rchk(GROUP_BASE[g] + SET_OFS, 4'hF, rst_v[g]);
			chk(prot[g], rst_v[g] & msk_v[g]);
		end
		rchk(IRQ_MASK_ADDR, 4'hF, 32'h0000_0000);
		// protect every peripheral; group 1 bit 1 is protected already
		for (int g = 0; g < 3; g++) begin
			wr(GROUP_BASE[g] + SET_OFS, 32'hFF7F_FFFF, 4'hF, g == 1);
			rchk(GROUP_BASE[g] + CLR_OFS, 4'hF, rst_v[g] | msk_v[g]);
			chk(prot[g], msk_v[g]);
		end
		pm_u.peri_write(2'h2, 5'h09, blk, err);
		chk(blk, 1'b1);
		chk(err, 1'b1);
		pm_u.peri_write(2'h0, 5'h00, blk, err);
		chk({blk, err}, 2'h0);
		pm_u.peri_write(2'h3, 5'h01, blk, err);
		chk({blk, err}, 2'h0);
		// byte lane clear, then lane-masked read
		wr(GROUP_BASE[2] + CLR_OFS, 32'hFFFF_FFFF, 4'b0010, 1'b0);
		rchk(GROUP_BASE[2] + CLR_OFS, 4'hF, 32'h008F_00FE);
		rchk(GROUP_BASE[2] + SET_OFS, 4'b0100, 32'h008F_0000);
		chk(prot[2], 32'h000F_00FE);
		wr(GROUP_BASE[0] + CLR_OFS, 32'hFFFF_FFFF, 4'b0011, 1'b0);
		rchk(GROUP_BASE[0] + SET_OFS, 4'hF, 32'h0000_0000);
		wr(GROUP_BASE[2] + SET_OFS, 32'h0000_0000, 4'hF, 1'b0);
		wr(GROUP_BASE[2] + CLR_OFS, 32'h0000_0000, 4'hF, 1'b0);
		rchk(GROUP_BASE[2] + CLR_OFS, 4'hF, 32'h008F_00FE);
		wr(GROUP_BASE[0] + CLR_OFS, 32'h0000_0002, 4'hF, 1'b1);
		pm_u.peri_write(2'h0, 5'h03, blk, err);
		chk({blk, err}, 2'h0);
		pm_u.peri_write(2'h1, 5'h01, blk, err);
		chk({blk, err}, 2'h3);
		// unmapped places read zero and take no write
		wr(8'h3C, 32'hFFFF_FFFF, 4'hF, 1'b0);
		rchk(8'h3C, 4'hF, 32'h0000_0000);
		rchk(8'h08, 4'hF, 32'h0000_0000);
		// interrupt: events masked, sticky status, read clears
		chk(irq, 1'b0);
		rchk(IRQ_STATUS_ADDR, 4'hF, 32'h0000_0007);
		rchk(IRQ_STATUS_ADDR, 4'hF, 32'h0000_0000);
		wr(IRQ_MASK_ADDR, 32'h0000_0004, 4'hF, 1'b0);
		rchk(IRQ_MASK_ADDR, 4'hF, 32'h0000_0004);
		chk(irq, 1'b0);
		pm_u.peri_write(2'h2, 5'h13, blk, err);
		chk({blk, err}, 2'h3);
		@(posedge clk);
		#1 chk(irq, 1'b1);
		// software reads the set register before touching shared state
		rchk(GROUP_BASE[2] + SET_OFS, 4'hF, 32'h008F_00FE);
		wr(GROUP_BASE[2] + SET_OFS, 32'h0008_0000, 4'hF, 1'b1);
		rchk(IRQ_STATUS_ADDR, 4'hF, 32'h0000_0005);
		@(posedge clk);
		#1 chk(irq, 1'b0);
		// a reset in mid-run brings every group back to its reset state
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		for (int g = 0; g < 3; g++) begin
			rchk(GROUP_BASE[g] + SET_OFS, 4'hF, rst_v[g]);
			chk(prot[g], rst_v[g] & msk_v[g]);
		end
		chk({guard_wr_err, irq}, 2'h0);
		summarize();
	end
endmodule // test_peripheral_write_protect
`default_nettype wire
